// ### core/frontend_spi_device.sv
// front-end end of the serial command port: registers, decoder, pin control
`default_nettype none
module frontend_spi_device (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    spi_link_if.device link,
    input wire logic i_demod_data,
    input wire logic i_carrier_clk,
    input wire logic i_alarm,
    input wire logic i_wake_detect,
    input wire logic i_inactivity_expired,
    input wire logic [7:0] i_strength_x,
    input wire logic [7:0] i_strength_y,
    input wire logic [7:0] i_strength_z,
    input wire logic [7:0] i_status_ext,
    output logic o_signal_strength_output_drive,
    output logic o_signal_strength_output_valid,
    output logic [7:0] o_signal_strength_output_level,
    output logic o_discharge_on,
    output logic o_timers_enable,
    output logic o_settle_bypass,
    output logic [2:0] o_op_mode,
    output logic o_clamp_on,
    output logic o_gain_hold,
    output logic o_soft_reset
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [1:0] sdio_sync;
    logic [1:0] demod_sync;
    logic [1:0] carrier_sync;

    // bit 0 is read only by bit 1; bit 2 exists for edge finding
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cs_sync <= 3'h7;
            sclk_sync <= 3'h0;
            sdio_sync <= 2'h0;
            demod_sync <= 2'h0;
            carrier_sync <= 2'h0;
        end
        else
        begin
            cs_sync <= {cs_sync[1:0], link.cs_n};
            sclk_sync <= {sclk_sync[1:0], link.sclk};
            sdio_sync <= {sdio_sync[0], link.sdio};
            demod_sync <= {demod_sync[0], i_demod_data};
            carrier_sync <= {carrier_sync[0], i_carrier_clk};
        end
    end

    // edges of the sampled link pins; clock edges count only inside a frame
    wire cs_low = ~cs_sync[1];
    wire cs_fall = ~cs_sync[1] & cs_sync[2];
    wire cs_rise = cs_sync[1] & ~cs_sync[2];
    wire sclk_rise = cs_low & ~cs_fall & sclk_sync[1] & ~sclk_sync[2];
    wire sclk_fall = cs_low & ~sclk_sync[1] & sclk_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    // frame receiver and decoder
    logic [3:0] bit_cnt;
    logic frame_seen;
    logic [15:0] shift_in;
    logic [15:0] frame;
    logic out_mode;
    logic [15:0] out_shift;
    logic read_pending;
    logic [3:0] read_addr;
    logic [8:0] regs [0:6];
    logic [8:0] status_word;

    wire [2:0] frame_cmd = frame[frontend_spi_pkg::CMD_MSB:frontend_spi_pkg::CMD_LSB];
    wire [3:0] frame_addr = frame[frontend_spi_pkg::ADDR_MSB:frontend_spi_pkg::ADDR_LSB];
    wire [8:0] frame_word = frame[frontend_spi_pkg::WORD_MSB:0];
    // a command runs only when select rises after whole 16-clock frames
    wire exec = cs_rise & frame_seen & (bit_cnt == 4'h0) & ~out_mode;
    wire exec_write = exec & (frame_cmd == frontend_spi_pkg::CMD_WRITE);
    wire write_ok = exec_write & (frame_addr < frontend_spi_pkg::FRONTEND_STATUS);
    wire [8:0] read_word = (read_addr == frontend_spi_pkg::FRONTEND_STATUS) ? status_word
                         : (read_addr < frontend_spi_pkg::FRONTEND_STATUS) ? regs[read_addr[2:0]]
                         : frontend_spi_pkg::REG_RESET;

    // shift in on rising edges; keep the last whole frame
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_cnt <= 4'h0;
            frame_seen <= 1'b0;
            shift_in <= 16'h0000;
            frame <= 16'h0000;
        end
        else if (cs_fall)
        begin
            bit_cnt <= 4'h0;
            frame_seen <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shift_in <= {shift_in[14:0], sdio_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == frontend_spi_pkg::LAST_BIT)
            begin
                frame_seen <= 1'b1;
                frame <= {shift_in[14:0], sdio_sync[1]};
            end
        end
    end

    // read entry arms the next frame as a result frame
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            read_pending <= 1'b0;
            read_addr <= 4'h0;
            out_mode <= 1'b0;
            out_shift <= 16'h0000;
        end
        else if (cs_fall)
        begin
            out_mode <= read_pending;
            // the select gap stands as the first clock, so data follows the seven dummy bits
            out_shift <= {frontend_spi_pkg::READ_DUMMY, read_word};
        end
        else if (cs_rise)
        begin
            read_pending <= exec & (frame_cmd == frontend_spi_pkg::CMD_READ);
            read_addr <= frame_addr;
            out_mode <= 1'b0;
        end
        else if (sclk_fall & out_mode)
        begin
            out_shift <= {out_shift[14:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers, cleared at power-up
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < frontend_spi_pkg::NUM_CONFIG; i++)
            begin
                regs[i] <= frontend_spi_pkg::REG_RESET;
            end
        end
        else if (write_ok)
        begin
            regs[frame_addr[2:0]] <= frame_word;
        end
    end

    // parity is stored as written; a bad row or column raises the error flag
    logic row_bad;
    logic [7:0] column;
    always_comb
    begin
        row_bad = 1'b0;
        column = 8'h00;
        for (int i = 0; i < frontend_spi_pkg::NUM_CONFIG; i++)
        begin
            row_bad = row_bad | ~frontend_spi_pkg::odd_ok(regs[i]);
            column = column ^ regs[i][8:1];
        end
    end
    wire parity_err = row_bad | (column != frontend_spi_pkg::COLUMN_ALL_ODD);
    assign status_word = {i_status_ext, parity_err};

    ////////////////////////////////////////////////////////////////////////////
    // output type and strength path
    wire [8:0] fmt = regs[frontend_spi_pkg::X_TUNING_OUTPUT_FORMAT[2:0]];
    wire signal_strength_output_mode = fmt[frontend_spi_pkg::TYPE_HI];
    wire carrier_mode = ~fmt[frontend_spi_pkg::TYPE_HI] & fmt[frontend_spi_pkg::TYPE_LO];
    wire [8:0] opts = regs[frontend_spi_pkg::GENERAL_OPTIONS[2:0]];
    wire [2:0] ch_en = ~opts[frontend_spi_pkg::CH_DIS_Z:frontend_spi_pkg::CH_DIS_X];
    wire [7:0] sx = ch_en[0] ? i_strength_x : 8'h00;
    wire [7:0] sy = ch_en[1] ? i_strength_y : 8'h00;
    wire [7:0] sz = ch_en[2] ? i_strength_z : 8'h00;
    wire [7:0] sxy = (sx > sy) ? sx : sy;
    wire [7:0] strongest = (sxy > sz) ? sxy : sz;
    wire rx_bit = carrier_mode ? carrier_sync[1] : demod_sync[1];
    wire alert_cond = parity_err | (opts[frontend_spi_pkg::ALERT_ALARM_BIT] & i_alarm);

    logic pin_out;
    logic alert_oe;
    logic [7:0] signal_strength_output_level;

    // pin data comes from a flop; alert is only raised outside frames
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_out <= 1'b0;
            alert_oe <= 1'b0;
            signal_strength_output_level <= 8'h00;
        end
        else
        begin
            pin_out <= out_mode ? out_shift[15] : rx_bit;
            alert_oe <= ~cs_low & alert_cond;
            signal_strength_output_level <= strongest;
        end
    end

    // receive output while select high outside strength mode, input or result output while low
    assign link.dev_sdio_o = pin_out;
    assign link.dev_sdio_oe = cs_low ? out_mode : ~signal_strength_output_mode;
    assign link.dev_alert_oe = alert_oe;
    assign o_signal_strength_output_drive = signal_strength_output_mode & ~cs_low;
    assign o_signal_strength_output_valid = signal_strength_output_mode & (|ch_en);
    assign o_signal_strength_output_level = signal_strength_output_level;
    assign o_discharge_on = signal_strength_output_mode
        & regs[frontend_spi_pkg::Y_TUNING[2:0]][frontend_spi_pkg::DISCHARGE_BIT];
    assign o_timers_enable = ~signal_strength_output_mode;
    assign o_settle_bypass = signal_strength_output_mode;

    ////////////////////////////////////////////////////////////////////////////
    // operating mode and command-only actions
    frontend_spi_pkg::op_mode_t op_mode;
    frontend_spi_pkg::op_mode_t next_op_mode;
    wire exec_cmd_only = exec & (frame_cmd <= frontend_spi_pkg::CMD_SOFT_RESET);
    wire is_cmd_sleep = exec & (frame_cmd == frontend_spi_pkg::CMD_SLEEP);

    // strength mode overrides everything; any command but sleep wakes from sleep
    always_comb
    begin
        next_op_mode = op_mode;
        case (op_mode)
            frontend_spi_pkg::MODE_SLEEP:
                if (exec & ~is_cmd_sleep)
                    next_op_mode = frontend_spi_pkg::MODE_STANDBY;
            frontend_spi_pkg::MODE_STANDBY:
                if (is_cmd_sleep)
                    next_op_mode = frontend_spi_pkg::MODE_SLEEP;
                else if (i_wake_detect)
                    next_op_mode = frontend_spi_pkg::MODE_ACTIVE;
            frontend_spi_pkg::MODE_ACTIVE:
                if (is_cmd_sleep)
                    next_op_mode = frontend_spi_pkg::MODE_SLEEP;
                else if (i_inactivity_expired & ~signal_strength_output_mode)
                    next_op_mode = frontend_spi_pkg::MODE_STANDBY;
            default:
                next_op_mode = frontend_spi_pkg::MODE_STANDBY;
        endcase
        if (signal_strength_output_mode)
            next_op_mode = frontend_spi_pkg::MODE_ACTIVE;
    end

    // clamp survives a soft reset; soft reset only acts while active
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            op_mode <= frontend_spi_pkg::MODE_STANDBY;
            o_clamp_on <= 1'b0;
            o_gain_hold <= 1'b0;
            o_soft_reset <= 1'b0;
        end
        else
        begin
            op_mode <= next_op_mode;
            o_soft_reset <= exec & (frame_cmd == frontend_spi_pkg::CMD_SOFT_RESET)
                & (op_mode == frontend_spi_pkg::MODE_ACTIVE);
            if (exec_cmd_only & (frame_cmd == frontend_spi_pkg::CMD_CLAMP_ON))
                o_clamp_on <= 1'b1;
            else if (exec_cmd_only & (frame_cmd == frontend_spi_pkg::CMD_CLAMP_OFF))
                o_clamp_on <= 1'b0;
            if (exec_cmd_only & (frame_cmd == frontend_spi_pkg::CMD_HOLD_ON))
                o_gain_hold <= 1'b1;
            else if (exec_cmd_only & (frame_cmd == frontend_spi_pkg::CMD_HOLD_OFF))
                o_gain_hold <= 1'b0;
        end
    end

    assign o_op_mode = op_mode;
endmodule : frontend_spi_device
`default_nettype wire

// ### core/frontend_spi_host.sv
// host end of the serial command port: frame sequencer and clock divider
`default_nettype none
module frontend_spi_host (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    spi_link_if.host link,
    input wire logic i_req,
    input wire logic [2:0] i_cmd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_data,
    output logic o_busy,
    output logic o_rd_valid,
    output logic [8:0] o_rd_data,
    output logic o_alert
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; bit 0 feeds only bit 1
    logic [1:0] sdio_sync;
    logic [1:0] sclk_sync;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sdio_sync <= 2'h0;
            sclk_sync <= 2'h3;
        end
        else
        begin
            sdio_sync <= {sdio_sync[0], link.sdio};
            sclk_sync <= {sclk_sync[0], link.sclk};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    frontend_spi_pkg::host_state_t state;
    logic [3:0] cnt;
    logic [3:0] bitc;
    logic [15:0] tx;
    logic [15:0] rx;
    logic is_read;
    logic second;
    logic sclk_o;
    logic sclk_oe;
    logic cs_o;
    logic sdio_oe;

    wire half_done = (cnt == frontend_spi_pkg::HALF_LAST);
    // the device sees select two flops late, so the data line turns round mid half period
    wire turn_done = (cnt == (frontend_spi_pkg::HALF_LAST >> 1));
    wire req_read = (i_cmd == frontend_spi_pkg::CMD_READ);
    // a read entry carries dummy data; parity makes the nine bits odd
    wire [7:0] tx_byte = req_read ? frontend_spi_pkg::DUMMY_BYTE : i_data;
    wire [15:0] tx_frame = {i_cmd, i_addr, tx_byte, ~^tx_byte};

    // the counter paces every half period of the link clock
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt <= 4'h0;
        else if (state == frontend_spi_pkg::H_IDLE || half_done)
            cnt <= 4'h0;
        else
            cnt <= cnt + 4'h1;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= frontend_spi_pkg::H_IDLE;
            bitc <= 4'h0;
            tx <= 16'h0000;
            rx <= 16'h0000;
            is_read <= 1'b0;
            second <= 1'b0;
            sclk_o <= 1'b0;
            sclk_oe <= 1'b0;
            cs_o <= 1'b1;
            sdio_oe <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 9'h000;
        end
        else
        begin
            o_rd_valid <= 1'b0;
            case (state)
                frontend_spi_pkg::H_IDLE:
                    if (i_req)
                    begin
                        tx <= tx_frame;
                        is_read <= req_read;
                        second <= 1'b0;
                        sclk_o <= 1'b0;
                        sclk_oe <= 1'b1;
                        state <= frontend_spi_pkg::H_PREP;
                    end
                frontend_spi_pkg::H_PREP:
                    if (half_done)
                    begin
                        cs_o <= 1'b0;
                        bitc <= 4'h0;
                        state <= frontend_spi_pkg::H_SHIFT;
                    end
                frontend_spi_pkg::H_SHIFT:
                begin
                    // drive only once the device has stopped driving the shared pin
                    if (!second && !sclk_o && bitc == 4'h0 && turn_done)
                        sdio_oe <= 1'b1;
                    if (half_done && !sclk_o)
                    begin
                        sclk_o <= 1'b1;
                        rx <= {rx[14:0], sdio_sync[1]};
                    end
                    else if (half_done)
                    begin
                        sclk_o <= 1'b0;
                        tx <= {tx[14:0], 1'b0};
                        bitc <= bitc + 4'h1;
                        if (bitc == frontend_spi_pkg::LAST_BIT)
                        begin
                            sdio_oe <= 1'b0;
                            state <= frontend_spi_pkg::H_TAIL;
                        end
                    end
                end
                frontend_spi_pkg::H_TAIL:
                    if (half_done)
                    begin
                        cs_o <= 1'b1;
                        state <= frontend_spi_pkg::H_GAP;
                    end
                frontend_spi_pkg::H_GAP:
                    if (half_done && is_read && !second)
                    begin
                        // result frame: the data line stays released
                        second <= 1'b1;
                        cs_o <= 1'b0;
                        bitc <= 4'h0;
                        state <= frontend_spi_pkg::H_SHIFT;
                    end
                    else if (half_done)
                    begin
                        sclk_oe <= 1'b0;
                        o_rd_valid <= is_read;
                        if (is_read)
                            o_rd_data <= rx[8:0];
                        state <= frontend_spi_pkg::H_IDLE;
                    end
                default:
                    state <= frontend_spi_pkg::H_IDLE;
            endcase
        end
    end

    // alert is only meaningful while the clock line is released
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_alert <= 1'b0;
        else
            o_alert <= ~sclk_oe & ~sclk_sync[1];
    end

    // the data pin is driven only while sending a frame, never while select is high
    assign link.host_sdio_o = tx[15];
    assign link.host_sdio_oe = sdio_oe;
    assign link.host_sclk_o = sclk_o;
    assign link.host_sclk_oe = sclk_oe;
    assign link.host_cs_n_o = cs_o;
    assign link.host_cs_n_oe = 1'b1;
    assign o_busy = (state != frontend_spi_pkg::H_IDLE);
endmodule : frontend_spi_host
`default_nettype wire

// ### pkg/frontend_spi_pkg.sv
// shared constants, types and helpers for the front-end serial command port
`default_nettype none
package frontend_spi_pkg;
    // frame layout, most significant bit first
    localparam int FRAME_BITS = 16;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 13;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 9;
    localparam int WORD_MSB = 8;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam logic [6:0] READ_DUMMY = 7'h00;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;

    // register offsets
    localparam logic [3:0] GENERAL_OPTIONS = 4'h0;
    localparam logic [3:0] X_TUNING_OUTPUT_FORMAT = 4'h1;
    localparam logic [3:0] Y_TUNING = 4'h2;
    localparam logic [3:0] Z_TUNING = 4'h3;
    localparam logic [3:0] XY_SENSITIVITY = 4'h4;
    localparam logic [3:0] Z_SENSITIVITY_MODULATION = 4'h5;
    localparam logic [3:0] COLUMN_PARITY = 4'h6;
    localparam logic [3:0] FRONTEND_STATUS = 4'h7;
    localparam int NUM_CONFIG = 7;
    localparam logic [8:0] REG_RESET = 9'h000;
    localparam logic [7:0] COLUMN_ALL_ODD = 8'hff;

    // field positions
    localparam int TYPE_HI = 8;             // output_type_select upper bit
    localparam int TYPE_LO = 7;             // output_type_select lower bit
    localparam int DISCHARGE_BIT = 8;       // discharge_pulldown_enable
    localparam int ALERT_ALARM_BIT = 4;
    localparam int CH_DIS_X = 1;
    localparam int CH_DIS_Z = 3;

    // link timing
    localparam int CORE_PERIOD_NS = 4;
    localparam int SCLK_HALF_NS = 32;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);

    typedef enum logic [2:0]
    {
        CMD_CLAMP_ON = 3'h0,
        CMD_CLAMP_OFF = 3'h1,
        CMD_SLEEP = 3'h2,
        CMD_HOLD_ON = 3'h3,
        CMD_HOLD_OFF = 3'h4,
        CMD_SOFT_RESET = 3'h5,
        CMD_READ = 3'h6,
        CMD_WRITE = 3'h7
    } cmd_t;

    typedef enum logic [2:0]
    {
        MODE_STANDBY = 3'h1,
        MODE_ACTIVE = 3'h2,
        MODE_SLEEP = 3'h4
    } op_mode_t;

    typedef enum logic [4:0]
    {
        H_IDLE = 5'h01,
        H_PREP = 5'h02,
        H_SHIFT = 5'h04,
        H_TAIL = 5'h08,
        H_GAP = 5'h10
    } host_state_t;

    // true when the nine bits hold an odd number of ones
    function automatic logic odd_ok(input logic [8:0] v);
        return ^v;
    endfunction : odd_ok
endpackage : frontend_spi_pkg
`default_nettype wire

// ### pkg/spi_link_if.sv
// three-pin link between host and front end, with wired pin resolution
`default_nettype none
interface spi_link_if;
    logic host_cs_n_o;
    logic host_cs_n_oe;
    logic host_sclk_o;
    logic host_sclk_oe;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_alert_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic cs_n;
    logic sclk;
    logic sdio;

    // select idles high through the pull-up when nobody drives it
    assign cs_n = host_cs_n_oe ? host_cs_n_o : 1'b1;
    // open-collector alert pulls the shared clock line low
    assign sclk = ~dev_alert_oe & (host_sclk_oe ? host_sclk_o : 1'b1);
    // an undriven data line reads low
    assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe & host_sdio_o);

    modport host (
        output host_cs_n_o, host_cs_n_oe, host_sclk_o, host_sclk_oe,
        output host_sdio_o, host_sdio_oe,
        input cs_n, sclk, sdio
    );
    modport device (
        output dev_alert_oe, dev_sdio_o, dev_sdio_oe,
        input cs_n, sclk, sdio
    );
endinterface : spi_link_if
`default_nettype wire

// ### tb/frontend_spi_checker.sv
// concurrent checks on the three-pin link between host and front end
`default_nettype none
module frontend_spi_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_oe,
    input wire logic dev_alert_oe
);
    logic [3:0] rises;
    logic sclk_q;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // link clock rises inside one select window, modulo a frame
    always_ff @(posedge i_core_clk or negedge i_rst_n)
        if (!i_rst_n)
            {rises, sclk_q} <= 5'h00;
        else
            {rises, sclk_q} <= {cs_n ? 4'h0 : rises + 4'(sclk & ~sclk_q), sclk};
    // a half period that is too short would beat the device's edge finder
    sequence clk_high_s;
        sclk [*7];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    data_no_clash_a: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive data");
    // the device needs three cycles to see select fall and let go of the line
    alert_in_frame_a: assert property (!cs_n && !$past(cs_n, 3) |-> !dev_alert_oe)
        else $error("alert pulled inside frame");
    clk_low_select_a: assert property ($fell(cs_n) |-> !sclk)
        else $error("clock high at select fall");
    host_data_select_a: assert property (host_sdio_oe |-> !cs_n)
        else $error("host drives data outside frame");
    release_before_rise_a: assert property ($rose(cs_n) |-> !$past(host_sdio_oe))
        else $error("data held at select rise");
    whole_frames_a: assert property ($rose(cs_n) |-> rises == 4'h0)
        else $error("clock count not whole frames");
    clk_half_a: assert property ($rose(sclk) && !cs_n |=> clk_high_s)
        else $error("link clock high too short");
    select_gap_a: assert property ($rose(cs_n) |=> cs_n [*7])
        else $error("select gap too short");
endmodule : frontend_spi_checker
`default_nettype wire

// ### tb/tb_frontend_spi_command_port.sv
// bench joining host and front end, with a register and mode model
`default_nettype none
module tb_frontend_spi_command_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_demod_data = 1'b0;
    logic i_carrier_clk = 1'b0, i_alarm = 1'b0, i_wake_detect = 1'b0, i_inactivity_expired = 1'b0;
    logic [2:0] i_cmd = 3'h0, o_op_mode;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_data = 8'h00, i_strength_x = 8'h00, i_strength_y = 8'h00;
    logic [7:0] i_strength_z = 8'h00, i_status_ext = 8'h00, o_signal_strength_output_level;
    logic o_busy, o_rd_valid, o_alert, o_signal_strength_output_drive, o_signal_strength_output_valid, o_discharge_on;
    logic o_timers_enable, o_settle_bypass, o_clamp_on, o_gain_hold, o_soft_reset;
    logic [8:0] o_rd_data;
    logic [8:0] mreg [7] = '{default: 9'h000};
    int miscompares = 0, total_checks = 0, nsr = 0, nrv = 0;
    spi_link_if link ();
    frontend_spi_host frontend_spi_host_inst (.*);
    frontend_spi_device frontend_spi_device_inst (.*);
    frontend_spi_checker frontend_spi_checker_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .cs_n(link.cs_n), .sclk(link.sclk), .host_sdio_oe(link.host_sdio_oe),
        .dev_sdio_oe(link.dev_sdio_oe), .dev_alert_oe(link.dev_alert_oe));
    ////////////////////////////////////////////////////////////////////////////
    // clock, random pin data, soft reset pulse counter
    always #2 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) {i_demod_data, i_carrier_clk} <= 2'($urandom);
    always @(posedge i_core_clk) nsr += (o_soft_reset === 1'b1);
    always @(posedge i_core_clk) nrv += (o_rd_valid === 1'b1);
    // watchdog: the full run needs about 47 us, well under this 200 us limit
    initial
    begin
        #200000;
        miscompares++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] colx();
        colx = 8'h00;
        for (int i = 0; i < 6; i++)
            colx ^= mreg[i][8:1];
    endfunction : colx
    // expected error flag: any even row or columns not all odd
    function automatic logic perr();
        perr = (colx() ^ mreg[6][8:1]) != 8'hff;
        for (int i = 0; i < 7; i++)
            perr |= ~^mreg[i];
    endfunction : perr
    // strongest enabled channel, zero when all are off
    function automatic logic [7:0] strongest_exp();
        logic [7:0] s [3];
        s = '{i_strength_x, i_strength_y, i_strength_z};
        strongest_exp = 8'h00;
        for (int i = 0; i < 3; i++)
            if (!mreg[0][i + 1] && s[i] > strongest_exp)
                strongest_exp = s[i];
    endfunction : strongest_exp
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one user request; the model follows only writes the device keeps
    task automatic xfer(input logic [2:0] c, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        {i_req, i_cmd, i_addr, i_data} <= {1'b1, c, a, d};
        @(posedge i_core_clk);
        i_req <= 1'b0;
        @(negedge i_core_clk);
        for (int n = 0; n < 2000 && o_busy !== 1'b0; n++)
            @(negedge i_core_clk);
        chk("busy", o_busy, 1'b0);
        repeat (6) @(negedge i_core_clk);
        if (c == 3'h7 && a < 4'h7)
            mreg[a[2:0]] = {d, ~^d};
    endtask : xfer
    task automatic rd(input logic [3:0] a);
        xfer(3'h6, a, 8'h00);
        chk("read", o_rd_data, a < 7 ? mreg[a[2:0]] : a == 7 ? {i_status_ext, perr()} : 9'h0);
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h32198181));
        repeat (5) @(posedge i_core_clk);
        {i_rst_n, i_strength_x, i_strength_y, i_strength_z, i_status_ext} <= {1'b1, $urandom};
        rd(4'h7);
        chk("alert", o_alert, 1'b1);
        // good rows, column row closes the columns, status write dropped
        for (int a = 0; a < 7; a++)
            xfer(3'h7, 4'(a), a == 6 ? ~colx() : 8'(a == 1 ? 8'h3f & $urandom : $urandom));
        xfer(3'h7, 4'h7, 8'h55);
        for (int a = 0; a < 9; a++)
            rd(4'(a));
        chk("rdvalid", 9'(nrv), 9'h00a);
        chk("alert", o_alert, 1'b0);
        $display("test registers done");
        // command-only codes in standby, hold-on sent from sleep; soft reset in standby is ignored
        for (int c = 0; c < 6; c++)
        begin
            xfer(3'(c), 4'(c), 8'(c));
            chk("cmd", {o_clamp_on, o_gain_hold, o_op_mode}, {c == 0, c == 3, c == 2 ? 3'h4 : 3'h1});
        end
        chk("sreset", 9'(nsr), 9'h000);
        $display("test commands done");
        // strength output with channel x enabled and discharge set
        xfer(3'h7, 4'h0, 8'($urandom) & 8'hfe);
        xfer(3'h7, 4'h2, 8'($urandom) | 8'h80);
        xfer(3'h7, 4'h1, 8'h80);
        chk("strength", {o_signal_strength_output_drive, o_discharge_on, o_timers_enable, o_settle_bypass, o_op_mode}, 7'h6a);
        chk("level", o_signal_strength_output_level, strongest_exp());
        xfer(3'h5, 4'h0, 8'h00);
        chk("sreset", 9'(nsr), 9'h001);
        xfer(3'h7, 4'h1, 8'hc0);
        xfer(3'h7, 4'h0, 8'h07);
        chk("hold", {o_signal_strength_output_drive, o_signal_strength_output_valid}, 2'h2);
        xfer(3'h7, 4'h1, 8'h40);
        chk("leave", {o_signal_strength_output_drive, o_discharge_on, o_timers_enable}, 3'h1);
        $display("test strength done");
        complete_run();
    end
endmodule : tb_frontend_spi_command_port
`default_nettype wire
